// ==== verilog/tx_fifo_trig_pkg.sv ====
/*
 * Shared constants for the per-channel transmit FIFO trigger logic:
 * register offsets, field positions, reset values and the access state type.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
`default_nettype none
package tx_fifo_trig_pkg;
    // Channel count and widths
    localparam int unsigned NUM_CH = 32;
    localparam int unsigned CH_W = 5;
    localparam int unsigned BLK_W = 10;
    localparam int unsigned BLOCK_BYTES = 16;

    // Register byte offsets
    localparam logic [11:0] TRIG_DATA_OFS = 12'h38c;
    localparam logic [11:0] CH_SEL_OFS = 12'h390;
    localparam logic [11:0] GLOBAL_CFG_OFS = 12'h394;

    // Staging data fields
    localparam int unsigned START_MODE_BIT = 15;
    localparam int unsigned LEVEL_LSB = 8;
    localparam int unsigned FLAG_LSB = 5;
    localparam int unsigned XFER_LSB = 0;

    // Channel select fields
    localparam int unsigned CH_LSB = 0;
    localparam int unsigned RWB_BIT = 14;
    localparam int unsigned BUSY_BIT = 15;

    // Global configuration fields
    localparam int unsigned BURST_LSB = 0;
    localparam int unsigned BURST_EN_BIT = 7;

    // Reset values
    localparam logic [15:0] TRIG_DATA_RST = 16'h0000;
    localparam logic [7:0] GLOBAL_CFG_RST = 8'h00;

    // Idle fill byte: eight ones
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    // Indirect access state
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_READ = 2'b10
    } acc_state_t;
endpackage
`default_nettype wire

// ==== verilog/tx_level_decode.sv ====
/*
 * Level table decoder: maps the level code and start mode to the expedite
 * and start transmission thresholds in blocks.
 * Purely combinational; used by the main trigger module.
 */
`timescale 1ns/1ps
`default_nettype none
module tx_level_decode
    import tx_fifo_trig_pkg::*;
(
    input wire logic [3:0] level_i,
    input wire logic start_mode_sel_i,
    output logic [BLK_W-1:0] expedite_o,
    output logic [BLK_W-1:0] start_o
);
    // Level code to block count tables
    always_comb begin
        unique case (level_i)
            4'h0: expedite_o = 10'h002;
            4'h1: expedite_o = 10'h003;
            4'h2: expedite_o = 10'h004;
            4'h3: expedite_o = 10'h006;
            4'h4: expedite_o = 10'h008;
            4'h5: expedite_o = 10'h00c;
            4'h6: expedite_o = 10'h010;
            4'h7: expedite_o = 10'h018;
            4'h8: expedite_o = 10'h020;
            4'h9: expedite_o = 10'h030;
            4'ha: expedite_o = 10'h040;
            4'hb: expedite_o = 10'h060;
            4'hc: expedite_o = 10'h080;
            4'hd: expedite_o = 10'h0c0;
            4'he: expedite_o = 10'h100;
            4'hf: expedite_o = 10'h180;
        endcase
        if (!start_mode_sel_i) begin
            unique case (level_i)
                4'h0: start_o = 10'h001;
                4'h1: start_o = 10'h002;
                4'h2: start_o = 10'h003;
                4'h3: start_o = 10'h004;
                4'h4: start_o = 10'h006;
                4'h5: start_o = 10'h008;
                4'h6: start_o = 10'h00c;
                4'h7: start_o = 10'h010;
                4'h8: start_o = 10'h018;
                4'h9: start_o = 10'h020;
                4'ha: start_o = 10'h030;
                4'hb: start_o = 10'h040;
                4'hc: start_o = 10'h060;
                4'hd: start_o = 10'h080;
                4'he: start_o = 10'h0c0;
                4'hf: start_o = 10'h100;
            endcase
        end else begin
            unique case (level_i)
                4'h0: start_o = 10'h001;
                4'h1: start_o = 10'h001;
                4'h2: start_o = 10'h002;
                4'h3: start_o = 10'h003;
                4'h4: start_o = 10'h004;
                4'h5: start_o = 10'h006;
                4'h6: start_o = 10'h008;
                4'h7: start_o = 10'h00c;
                4'h8: start_o = 10'h010;
                4'h9: start_o = 10'h018;
                4'ha: start_o = 10'h020;
                4'hb: start_o = 10'h030;
                4'hc: start_o = 10'h040;
                4'hd: start_o = 10'h060;
                4'he: start_o = 10'h080;
                4'hf: start_o = 10'h0c0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verilog/tx_channel_fifo_trigger_config.sv ====
/*
 * Per-channel transmit FIFO trigger and transfer-size logic with a
 * Wishbone slave holding a staging register and a per-channel provision
 * store. The channel under evaluation is chosen by eval_ch_i; the FIFO
 * status of that channel is presented on the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tx_channel_fifo_trigger_config
    import tx_fifo_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Channel FIFO status of the evaluated channel
    input wire logic [CH_W-1:0] eval_ch_i,
    input wire logic [BLK_W-1:0] free_blocks_i,
    input wire logic eop_held_i,
    input wire logic sending_i,
    // Request toward the transmit DMA block
    output logic dma_req_o,
    output logic dma_exp_o,
    output logic [CH_W-1:0] dma_ch_o,
    output logic [BLK_W-1:0] dma_blocks_o,
    // Transmit HDLC unit controls
    output logic start_tx_o,
    output logic [7:0] min_flags_o,
    output logic [7:0] min_idle_bytes_o,
    output logic [7:0] idle_fill_byte_o
);
    // Staging, channel select and global configuration
    logic [15:0] stage_q;
    logic [CH_W-1:0] ch_sel_q;
    logic rwb_q;
    logic [7:0] gcfg_q;
    acc_state_t acc_q;
    // Per-channel provision store: start mode, level, flag, transfer size
    logic [10:0] prov_mem [NUM_CH];

    // Pack staged fields into a provision word
    function automatic logic [10:0] pack_prov(input logic [15:0] s);
        pack_prov = {s[START_MODE_BIT], s[LEVEL_LSB +: 4], s[FLAG_LSB +: 3], s[XFER_LSB +: 3]};
    endfunction

    // Unpack a provision word into staging layout
    function automatic logic [15:0] unpack_prov(input logic [10:0] p);
        logic [15:0] s;
        s = 16'h0000;
        s[START_MODE_BIT] = p[10];
        s[LEVEL_LSB +: 4] = p[9:6];
        s[FLAG_LSB +: 3] = p[5:3];
        s[XFER_LSB +: 3] = p[2:0];
        unpack_prov = s;
    endfunction

    // Bus decode
    logic req;
    logic hit_data;
    logic hit_sel;
    logic hit_cfg;
    logic wr;
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign hit_data = adr_i == TRIG_DATA_OFS;
    assign hit_sel = adr_i == CH_SEL_OFS;
    assign hit_cfg = adr_i == GLOBAL_CFG_OFS;
    assign wr = req && we_i && (hit_data || hit_sel || hit_cfg);

    // One-cycle acknowledge, error on unmapped address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req && (hit_data || hit_sel || hit_cfg);
            err_o <= req && !(hit_data || hit_sel || hit_cfg);
        end
    end

    // Read data mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            if (hit_data) begin
                dat_o <= {16'h0000, stage_q};
            end else if (hit_sel) begin
                dat_o <= {16'h0000, acc_q != ACC_IDLE, rwb_q, 9'h000, ch_sel_q};
            end else if (hit_cfg) begin
                dat_o <= {24'h000000, gcfg_q};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    // Staging register: software writes, completed indirect read reloads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= TRIG_DATA_RST;
        end else if (acc_q == ACC_READ) begin
            stage_q <= unpack_prov(prov_mem[ch_sel_q]);
        end else if (wr && hit_data) begin
            if (sel_i[0]) begin
                stage_q[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
                stage_q[15:8] <= dat_i[15:8];
            end
        end
    end

    // Global burst configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gcfg_q <= GLOBAL_CFG_RST;
        end else if (wr && hit_cfg && sel_i[0]) begin
            gcfg_q <= dat_i[7:0];
        end
    end

    // Channel select write triggers the indirect access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch_sel_q <= '0;
            rwb_q <= 1'b0;
            acc_q <= ACC_IDLE;
        end else if (wr && hit_sel && acc_q == ACC_IDLE && sel_i[0] && sel_i[1]) begin
            ch_sel_q <= dat_i[CH_LSB +: CH_W];
            rwb_q <= dat_i[RWB_BIT];
            acc_q <= dat_i[RWB_BIT] ? ACC_READ : ACC_WRITE;
        end else begin
            acc_q <= ACC_IDLE;
        end
    end

    // Provision store write from staged fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                prov_mem[i] <= 11'h000;
            end
        end else if (acc_q == ACC_WRITE) begin
            prov_mem[ch_sel_q] <= pack_prov(stage_q);
        end
    end

    // Settings of the channel under evaluation
    logic [10:0] cur;
    logic [2:0] xfer;
    logic [2:0] flag;
    logic [BLK_W-1:0] exp_lvl;
    logic [BLK_W-1:0] start_lvl;
    logic [BLK_W-1:0] xfer_blocks;
    logic [BLK_W-1:0] burst_blocks;
    logic [BLK_W-1:0] req_blocks;
    logic burst_en;
    assign cur = prov_mem[eval_ch_i];
    assign xfer = cur[2:0];
    assign flag = cur[5:3];
    assign burst_en = gcfg_q[BURST_EN_BIT];
    assign xfer_blocks = BLK_W'(xfer) + 10'h001;
    assign burst_blocks = BLK_W'(gcfg_q[BURST_LSB +: 3]) + 10'h001;

    tx_level_decode u_level (
        .level_i(cur[9:6]),
        .start_mode_sel_i(cur[10]),
        .expedite_o(exp_lvl),
        .start_o(start_lvl)
    );

    // Request size: fixed code plus one, or variable up to the burst cap
    always_comb begin
        if (burst_en && xfer == 3'b000) begin
            req_blocks = (free_blocks_i < burst_blocks) ? free_blocks_i : burst_blocks;
        end else begin
            req_blocks = xfer_blocks;
        end
    end

    // Normal and expedited requests, transmit start
    logic normal_req;
    logic exp_req;
    assign normal_req = free_blocks_i != '0 && free_blocks_i >= xfer_blocks;
    assign exp_req = sending_i && !eop_held_i && free_blocks_i > exp_lvl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_req_o <= 1'b0;
            dma_exp_o <= 1'b0;
            dma_ch_o <= '0;
            dma_blocks_o <= '0;
            start_tx_o <= 1'b0;
        end else begin
            dma_req_o <= normal_req || exp_req;
            dma_exp_o <= exp_req;
            dma_ch_o <= eval_ch_i;
            dma_blocks_o <= req_blocks;
            start_tx_o <= free_blocks_i <= start_lvl || eop_held_i;
        end
    end

    // Minimum interframe fill
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            min_flags_o <= 8'h01;
            min_idle_bytes_o <= 8'h00;
            idle_fill_byte_o <= IDLE_BYTE;
        end else begin
            min_flags_o <= 8'h01 << flag;
            min_idle_bytes_o <= (flag < 3'h2) ? 8'h00 : (8'h01 << flag) - 8'h02;
            idle_fill_byte_o <= IDLE_BYTE;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tx_dma_model.sv ====
/* Model of the transmit DMA controller that takes block requests.
   Assumes the request port is a registered level sampled each clock. */
`timescale 1ns/1ps
`default_nettype none
module tx_dma_model
    import tx_fifo_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [BLK_W-1:0] blocks_i,
    output logic [BLK_W-1:0] taken_o
);
    // Record the size of each request it accepts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            taken_o <= '0;
        end else if (req_i) begin
            taken_o <= blocks_i;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tx_trig_checker.sv ====
/* Port assertions for the transmit FIFO trigger block.
   Assumes binding to the top module; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module tx_trig_checker
    import tx_fifo_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic [CH_W-1:0] eval_ch_i,
    input wire logic [BLK_W-1:0] free_blocks_i,
    input wire logic eop_held_i,
    input wire logic sending_i,
    input wire logic dma_req_o,
    input wire logic dma_exp_o,
    input wire logic [CH_W-1:0] dma_ch_o,
    input wire logic [BLK_W-1:0] dma_blocks_o,
    input wire logic start_tx_o,
    input wire logic [7:0] min_flags_o,
    input wire logic [7:0] min_idle_bytes_o,
    input wire logic [7:0] idle_fill_byte_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers and fill relations
    a_ack_single_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");
    a_answer_has_request: assert property (ack_o || err_o |-> $past(cyc_i && stb_i))
        else $error("answer without request");
    a_idle_byte_ones: assert property (idle_fill_byte_o == 8'hff)
        else $error("idle byte not all ones");
    a_flags_power_two: assert property ($onehot(min_flags_o))
        else $error("flag count not a power of two");
    a_idle_from_flags: assert property ((min_flags_o <= 8'h02) ? (min_idle_bytes_o == 8'h00)
        : (min_idle_bytes_o == min_flags_o - 8'h02)) else $error("idle count mismatch");
    // Request size and cause
    a_req_size_range: assert property (dma_req_o |-> dma_blocks_o inside {[1:8]})
        else $error("request size out of range");
    a_normal_fits_space: assert property (dma_req_o && !dma_exp_o
        |-> dma_blocks_o <= $past(free_blocks_i)) else $error("request exceeds free space");
    a_exp_needs_send: assert property (dma_exp_o |-> dma_req_o
        && $past(sending_i && !eop_held_i) && $past(free_blocks_i) > 10'h002)
        else $error("expedite without cause");
    a_req_own_channel: assert property (dma_req_o |-> dma_ch_o == $past(eval_ch_i))
        else $error("request channel mismatch");
    // Start of transmission
    a_eop_starts_tx: assert property (!$past(rst_i) && $past(eop_held_i) |-> start_tx_o)
        else $error("end of packet did not start");
    a_low_space_starts: assert property (!$past(rst_i) && $past(free_blocks_i) <= 10'h001
        |-> start_tx_o) else $error("low space did not start");
    c_expedite: cover property (dma_exp_o);
    c_normal_req: cover property (dma_req_o && !dma_exp_o);
    c_bus_error: cover property (err_o);
endmodule
bind tx_channel_fifo_trigger_config tx_trig_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .ack_o, .err_o, .eval_ch_i, .free_blocks_i, .eop_held_i, .sending_i, .dma_req_o,
    .dma_exp_o, .dma_ch_o, .dma_blocks_o, .start_tx_o, .min_flags_o, .min_idle_bytes_o,
    .idle_fill_byte_o);
`default_nettype wire

// ==== tb/tx_channel_fifo_trigger_config_tb.sv ====
/* Self-checking bench for the transmit FIFO trigger block.
   Assumes the Wishbone map and one-cycle output latency of the design. */
`timescale 1ns/1ps
`default_nettype none
module tx_channel_fifo_trigger_config_tb;
    import tx_fifo_trig_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, eop_held_i = 1'b0, sending_i = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [CH_W-1:0] eval_ch_i = '0, dma_ch_o;
    logic [BLK_W-1:0] free_blocks_i = '0, dma_blocks_o, taken;
    logic ack_o, err_o, berr, dma_req_o, dma_exp_o, start_tx_o;
    logic [7:0] min_flags_o, min_idle_bytes_o, idle_fill_byte_o;
    int err_count = 0, check_count = 0;
    int st0[16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256};
    int exq[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256, 384};
    always #2 clk_i = ~clk_i;
    tx_channel_fifo_trigger_config DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .err_o, .eval_ch_i, .free_blocks_i, .eop_held_i, .sending_i,
        .dma_req_o, .dma_exp_o, .dma_ch_o, .dma_blocks_o, .start_tx_o, .min_flags_o,
        .min_idle_bytes_o, .idle_fill_byte_o);
    tx_dma_model dma (.clk_i, .rst_i, .req_i(dma_req_o), .blocks_i(dma_blocks_o), .taken_o(taken));
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One classic Wishbone cycle, held until ack or err
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
        // Wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        berr = err_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    // Stage a value and write it to one channel
    task automatic prog(input logic [4:0] ch, input logic [31:0] d);
        wb(1'b1, TRIG_DATA_OFS, d);
        wb(1'b1, CH_SEL_OFS, {27'h0, ch});
        wb(1'b0, CH_SEL_OFS, 32'h0);
        chk("busy", 32'h0, {31'h0, rd[BUSY_BIT]});
    endtask
    // Present FIFO status and let outputs settle
    task automatic ev(input logic [4:0] ch, input int f, input logic e, input logic s);
        @(posedge clk_i);
        eval_ch_i <= ch;
        free_blocks_i <= f[9:0];
        eop_held_i <= e;
        sending_i <= s;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_reset;
        chk("idle_fill", 32'hff, {24'h0, idle_fill_byte_o});
        chk("flags_rst", 32'h1, {24'h0, min_flags_o});
        wb(1'b0, TRIG_DATA_OFS, 32'h0);
        chk("stage_rst", 32'h0, rd);
        wb(1'b0, 12'h000, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, berr});
    endtask
    task automatic t_levels;
        int st;
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 16; c++) begin
                st = (m == 0) ? st0[c] : ((c == 0) ? 1 : st0[c-1]);
                prog(5'h0, (m << 15) | (c << 8));
                ev(5'h0, st, 1'b0, 1'b0);
                chk("start_at", 32'h1, {31'h0, start_tx_o});
                ev(5'h0, st + 1, 1'b0, 1'b0);
                chk("start_above", 32'h0, {31'h0, start_tx_o});
                ev(5'h0, exq[c] + 1, 1'b0, 1'b1);
                chk("exp_above", 32'h1, {31'h0, dma_exp_o});
                ev(5'h0, exq[c], 1'b0, 1'b1);
                chk("exp_at", 32'h0, {31'h0, dma_exp_o});
            end
        end
        ev(5'h0, 500, 1'b1, 1'b1);
        chk("eop_start", 32'h1, {31'h0, start_tx_o});
        chk("eop_no_exp", 32'h0, {31'h0, dma_exp_o});
    endtask
    task automatic t_flags;
        for (int f = 0; f < 8; f++) begin
            prog(5'h1, f << 5);
            ev(5'h1, 0, 1'b0, 1'b0);
            chk("min_flags", 1 << f, {24'h0, min_flags_o});
            chk("min_idle", (f < 2) ? 0 : (1 << f) - 2, {24'h0, min_idle_bytes_o});
        end
    endtask
    task automatic t_size;
        for (int x = 1; x < 8; x++) begin
            prog(5'h2, 32'h0700 | x);
            ev(5'h2, x + 1, 1'b0, 1'b0);
            chk("req_size", x + 1, {22'h0, dma_blocks_o});
            chk("dma_taken", x + 1, {22'h0, taken});
            chk("req_ch", 32'h2, {27'h0, dma_ch_o});
            ev(5'h2, x, 1'b0, 1'b0);
            chk("no_req", 32'h0, {31'h0, dma_req_o});
        end
        wb(1'b1, GLOBAL_CFG_OFS, 32'h83);
        prog(5'h2, 32'h0);
        ev(5'h2, 20, 1'b0, 1'b0);
        chk("burst_cap", 32'h4, {22'h0, dma_blocks_o});
        ev(5'h2, 2, 1'b0, 1'b0);
        chk("burst_free", 32'h2, {22'h0, dma_blocks_o});
        wb(1'b1, GLOBAL_CFG_OFS, 32'h03);
        ev(5'h2, 20, 1'b0, 1'b0);
        chk("burst_off", 32'h1, {22'h0, dma_blocks_o});
    endtask
    task automatic t_indirect;
        prog(5'h3, 32'h0823);
        prog(5'h4, 32'h8060);
        wb(1'b1, TRIG_DATA_OFS, 32'hffff0005);
        wb(1'b0, TRIG_DATA_OFS, 32'h0);
        chk("stage_back", 32'h5, rd);
        wb(1'b1, CH_SEL_OFS, 32'h4003);
        wb(1'b0, CH_SEL_OFS, 32'h0);
        chk("sel_back", 32'h4003, rd);
        wb(1'b0, TRIG_DATA_OFS, 32'h0);
        chk("fetched", 32'h0823, rd);
        ev(5'h4, 0, 1'b0, 1'b0);
        chk("ch4_flags", 32'h8, {24'h0, min_flags_o});
        ev(5'h3, 0, 1'b0, 1'b0);
        chk("ch3_flags", 32'h2, {24'h0, min_flags_o});
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_levels();
        t_flags();
        t_size();
        t_indirect();
        final_report();
    end
    // Watchdog against a hung handshake
    initial begin
        #200000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
